/* rtl/per_defs.svh */
`ifndef PER_DEFS_SVH
`define PER_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PER_OFS_ASSIGN_BASE 8'h00
`define PER_OFS_LATCH 8'h20
`define PER_OFS_MASK 8'h24
`define PER_OFS_IRQ_STAT 8'h28
`define PER_OFS_IRQ_MASK 8'h2C

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define PER_NUM_SRC 64
`define PER_NUM_ASSIGN 8
`define PER_FIELD_W 4
`define PER_NUM_LVL 7
`define PER_LVL_BASE 4'h7
`define PER_EVT_W 16
`define PER_IRQ_W 2
`define PER_IRQ_PRIV 0
`define PER_IRQ_LOCKED 1

// ------------------------------------------------------------
// reset values (field value = level minus seven)
// ------------------------------------------------------------
`define PER_ASSIGN_RST0 32'h00000000
`define PER_ASSIGN_RST1 32'h11111000
`define PER_ASSIGN_RST2 32'h21111111
`define PER_ASSIGN_RST3 32'h22222222
`define PER_ASSIGN_RST4 32'h33333222
`define PER_ASSIGN_RST5 32'h43333333
`define PER_ASSIGN_RST6 32'h21144444
`define PER_ASSIGN_RST7 32'h00006552
`define PER_LATCH_RST 16'h0000
`define PER_MASK_RST 16'h0000
`define PER_IRQ_RST 2'h0

`endif

/* rtl/per_pkg.sv */
`include "per_defs.svh"

package per_pkg;
	// ------------------------------------------------------------
	// shared types
	// ------------------------------------------------------------
	typedef logic [`PER_NUM_SRC-1:0] per_src_t; // one bit per peripheral source
	typedef logic [`PER_NUM_LVL-1:0] per_lvl_t; // one bit per routed level
	typedef logic [`PER_EVT_W-1:0] per_evt_t; // one bit per core event class
	typedef logic [`PER_NUM_ASSIGN-1:0][31:0] per_assign_t; // assignment bank

	// router state
	typedef struct packed {
		per_lvl_t lvl_req; // registered per-level requests
	} per_route_s;

	// core event controller state
	typedef struct packed {
		per_assign_t assign_regs; // source assignment bank
		per_evt_t latch; // pending events
		per_evt_t mask; // enabled events
		logic [`PER_IRQ_W-1:0] irq_stat; // sticky fault flags
		logic [`PER_IRQ_W-1:0] irq_mask; // fault flag enables
		logic [31:0] rdata; // read data stage
	} per_core_s;
endpackage : per_pkg

/* rtl/per_level_router.sv */
`timescale 1ns/1ps
`include "per_defs.svh"

// maps each source whose field is below seven onto one routed level and ORs sources sharing a level
module per_level_router #(
	parameter int NUM_SRC = `PER_NUM_SRC,
	parameter int NUM_LVL = `PER_NUM_LVL,
	parameter int FIELD_W = `PER_FIELD_W
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire per_pkg::per_src_t src_i,
	input wire per_pkg::per_assign_t assign_i,
	output per_pkg::per_lvl_t lvl_req_o
);
	import per_pkg::*;

	per_route_s st; // registered state
	per_route_s next_st; // next state

	// ------------------------------------------------------------
	// decode each field and merge
	// ------------------------------------------------------------
	always_comb begin
		logic [FIELD_W-1:0] fld;
		fld = '0;
		next_st.lvl_req = '0;
		for (int s = 0; s < NUM_SRC; s++) begin
			// eight fields per 32-bit assignment word
			fld = assign_i[s / 8][(s % 8) * FIELD_W +: FIELD_W];
			for (int l = 0; l < NUM_LVL; l++) begin
				// shared levels are a plain OR of their sources
				if (src_i[s] && (fld == FIELD_W'(l))) begin
					next_st.lvl_req[l] = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// register stage keeps the long OR tree off the latch path
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lvl_req_o = st.lvl_req;
endmodule : per_level_router

/* rtl/per_event_router.sv */
`timescale 1ns/1ps
`include "per_defs.svh"

// How it works
// - sources routed by rewritable eight-register assignment bank
// - errors, wakeup, spares default to level seven
// - first dma channels 0-11 default level eight
// - second dma channels 0-11 default level nine
// - memory streams default eight or nine by controller
// - timers level ten, flag interrupts level eleven
// - inter-memory streams twelve, watchdog level thirteen
// - two sixteen-bit registers, one bit per class
// - latch sets on capture, clears on acceptance
// - latch writes cancel selected pending bits
// - latch access supervisor only, masked bits only
// - mask bit one services, zero blocks event
// - supervisor and user mode told apart
module per_event_router (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire per_pkg::per_src_t periph_src_i,
	input wire per_pkg::per_evt_t core_evt_i,
	input wire per_pkg::per_evt_t evt_accept_i,
	input wire logic supervisor_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output per_pkg::per_evt_t evt_req_o,
	output logic irq_o
);
	import per_pkg::*;

	// ------------------------------------------------------------
	// state and decode
	// ------------------------------------------------------------
	per_core_s st; // registered state
	per_core_s next_st; // next state
	per_lvl_t lvl_req; // routed level requests
	per_evt_t lat_set; // all captures this cycle
	per_evt_t cancel; // bits a legal latch write clears
	logic sel_assign; // address hits the assignment bank
	logic [2:0] assign_idx; // which assignment word
	logic aligned; // word aligned access

	// reset image of the assignment bank
	localparam per_assign_t ASSIGN_RST = {`PER_ASSIGN_RST7, `PER_ASSIGN_RST6,
		`PER_ASSIGN_RST5, `PER_ASSIGN_RST4, `PER_ASSIGN_RST3,
		`PER_ASSIGN_RST2, `PER_ASSIGN_RST1, `PER_ASSIGN_RST0};

	// ------------------------------------------------------------
	// system-level routing
	// ------------------------------------------------------------
	per_level_router #(
		.NUM_SRC(`PER_NUM_SRC),
		.NUM_LVL(`PER_NUM_LVL),
		.FIELD_W(`PER_FIELD_W)
	) u_route (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.src_i(periph_src_i),
		.assign_i(st.assign_regs),
		.lvl_req_o(lvl_req)
	);

	// routed levels land on latch bits seven to thirteen
	always_comb begin
		lat_set = core_evt_i;
		lat_set[`PER_LVL_BASE +: `PER_NUM_LVL] = core_evt_i[`PER_LVL_BASE +: `PER_NUM_LVL]
			| lvl_req;
	end

	// address decode; only whole-word offsets are mapped
	assign aligned = (addr_i[1:0] == 2'h0);
	assign sel_assign = aligned && (addr_i[7:5] == 3'h0);
	assign assign_idx = addr_i[4:2];

	// only supervisor writes cancel, and only where the mask is clear
	assign cancel = (wr_i && supervisor_i && addr_i == `PER_OFS_LATCH)
		? (wdata_i[15:0] & ~st.mask) : '0;

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rdata = 32'h00000000;
		// acceptance and cancel clear, capture sets; capture wins
		next_st.latch = (st.latch & ~evt_accept_i & ~cancel) | lat_set;
		// sticky faults: set wins over the write-one clear; user writes clear nothing
		if (wr_i && supervisor_i && addr_i == `PER_OFS_IRQ_STAT) begin
			next_st.irq_stat = st.irq_stat & ~wdata_i[`PER_IRQ_W-1:0];
		end
		// writes
		if (wr_i) begin
			if (!supervisor_i) begin
				// user mode may touch nothing here
				next_st.irq_stat[`PER_IRQ_PRIV] = 1'b1;
			end else if (sel_assign) begin
				next_st.assign_regs[assign_idx] = wdata_i;
			end else if (addr_i == `PER_OFS_LATCH) begin
				// bits under a set mask stay; report the attempt
				if ((wdata_i[15:0] & st.mask) != '0) begin
					next_st.irq_stat[`PER_IRQ_LOCKED] = 1'b1;
				end
			end else if (addr_i == `PER_OFS_MASK) begin
				next_st.mask = wdata_i[15:0];
			end else if (addr_i == `PER_OFS_IRQ_MASK) begin
				next_st.irq_mask = wdata_i[`PER_IRQ_W-1:0];
			end
		end
		// reads; unmapped reads and user reads of the latch give zero
		if (rd_i) begin
			if (sel_assign) begin
				next_st.rdata = st.assign_regs[assign_idx];
			end else if (addr_i == `PER_OFS_LATCH) begin
				if (supervisor_i) begin
					next_st.rdata = {16'h0000, st.latch};
				end else begin
					next_st.irq_stat[`PER_IRQ_PRIV] = 1'b1;
				end
			end else if (addr_i == `PER_OFS_MASK) begin
				next_st.rdata = {16'h0000, st.mask};
			end else if (addr_i == `PER_OFS_IRQ_STAT) begin
				next_st.rdata = {30'h00000000, st.irq_stat};
			end else if (addr_i == `PER_OFS_IRQ_MASK) begin
				next_st.rdata = {30'h00000000, st.irq_mask};
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			// bank wakes with the default routing, so events flow before setup
			st.assign_regs <= ASSIGN_RST;
			st.latch <= `PER_LATCH_RST;
			st.mask <= `PER_MASK_RST;
			st.irq_stat <= `PER_IRQ_RST;
			st.irq_mask <= `PER_IRQ_RST;
			st.rdata <= 32'h00000000;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// read data come from a flop, so the bus sees one clean word
	assign rdata_o = st.rdata;
	// combinational handshake toward the core
	assign evt_req_o = st.latch & st.mask;
	assign irq_o = |(st.irq_stat & st.irq_mask);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_route_capture;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(lvl_req != '0) |=> ((st.latch[`PER_LVL_BASE +: `PER_NUM_LVL] & $past(lvl_req))
			== $past(lvl_req));
	endproperty
	a_route_capture: assert property (p_route_capture)
		else $error("routed level request not latched");

	property p_accept_clear;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(evt_accept_i != '0) |=> ((st.latch & $past(evt_accept_i) & ~$past(lat_set)) == '0);
	endproperty
	a_accept_clear: assert property (p_accept_clear)
		else $error("accepted event still latched");

	property p_set_wins;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && addr_i == `PER_OFS_LATCH) |=> ((st.latch & $past(lat_set)) == $past(lat_set));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("capture lost against latch write");

	property p_masked_kept;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && addr_i == `PER_OFS_LATCH) |=> ((st.latch & $past(st.mask))
			== (($past(st.latch) & ~$past(evt_accept_i) | $past(lat_set)) & $past(st.mask)));
	endproperty
	a_masked_kept: assert property (p_masked_kept)
		else $error("latch write changed an unmasked-protected bit");

	property p_user_no_cancel;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && !supervisor_i) |=> (st.latch
			== (($past(st.latch) & ~$past(evt_accept_i)) | $past(lat_set)));
	endproperty
	a_user_no_cancel: assert property (p_user_no_cancel)
		else $error("user write altered latch");

	// the core request is a pure function of latch and mask
	property p_req_gated;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		((evt_req_o & ~st.mask) == '0) && ((evt_req_o & ~st.latch) == '0)
			&& ((evt_req_o | ~(st.latch & st.mask)) == '1);
	endproperty
	a_req_gated: assert property (p_req_gated)
		else $error("core request disagrees with latch and mask");

	property p_reset_defaults;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		!$past(reset_n_i) |-> (st.assign_regs == ASSIGN_RST) && (st.latch == (lat_set & 16'h0000));
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("assignment bank not at reset defaults");

	property p_assign_write;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && supervisor_i && sel_assign) |=> (st.assign_regs[$past(assign_idx)]
			== $past(wdata_i));
	endproperty
	a_assign_write: assert property (p_assign_write)
		else $error("assignment write not stored");

	property p_latch_read;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_i && addr_i == `PER_OFS_LATCH) |=> (rdata_o
			== ($past(supervisor_i) ? {16'h0000, $past(st.latch)} : 32'h00000000));
	endproperty
	a_latch_read: assert property (p_latch_read)
		else $error("latch read data wrong");

	property p_user_fault;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && !supervisor_i) |=> st.irq_stat[`PER_IRQ_PRIV] ##1 1'b1;
	endproperty
	a_user_fault: assert property (p_user_fault)
		else $error("user write did not flag fault");

	// ------------------------------------------------------------
	// register bus, privilege and core capture checks
	// ------------------------------------------------------------
	// each write check looks one cycle on, where the write has landed
	property p_mask_write;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && supervisor_i && addr_i == `PER_OFS_MASK) |=> (st.mask == $past(wdata_i[15:0]));
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write not stored");

	property p_cancel_clear;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && supervisor_i && addr_i == `PER_OFS_LATCH) |=> ((st.latch
			& $past(wdata_i[15:0]) & ~$past(st.mask) & ~$past(lat_set)) == '0);
	endproperty
	a_cancel_clear: assert property (p_cancel_clear)
		else $error("cancelled event still latched");

	property p_locked_flag;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && supervisor_i && addr_i == `PER_OFS_LATCH && (wdata_i[15:0] & st.mask) != '0)
			|=> st.irq_stat[`PER_IRQ_LOCKED];
	endproperty
	a_locked_flag: assert property (p_locked_flag)
		else $error("refused cancel not reported");

	property p_core_capture;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(core_evt_i != '0) |=> ((st.latch & $past(core_evt_i)) == $past(core_evt_i));
	endproperty
	a_core_capture: assert property (p_core_capture)
		else $error("core event not latched");

	property p_user_ignored;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(wr_i && !supervisor_i) |=> (st.mask == $past(st.mask))
			&& (st.assign_regs == $past(st.assign_regs)) && (st.irq_mask == $past(st.irq_mask));
	endproperty
	a_user_ignored: assert property (p_user_ignored)
		else $error("user write changed a register");

	property p_user_read_fault;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rd_i && !supervisor_i && addr_i == `PER_OFS_LATCH) |=> st.irq_stat[`PER_IRQ_PRIV];
	endproperty
	a_user_read_fault: assert property (p_user_read_fault)
		else $error("user latch read did not flag fault");

	// read data stand one cycle only; a stale word would mislead the next poll
	property p_rdata_idle;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		!rd_i |=> (rdata_o == 32'h00000000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside the answer cycle");

	// fault flags only fall under a supervisor write-one clear
	property p_stat_sticky;
		@(posedge ref_clk_i) disable iff (!reset_n_i)
		!(wr_i && supervisor_i && addr_i == `PER_OFS_IRQ_STAT)
			|=> ((st.irq_stat & $past(st.irq_stat)) == $past(st.irq_stat));
	endproperty
	a_stat_sticky: assert property (p_stat_sticky)
		else $error("fault flag dropped without a clear");
endmodule : per_event_router

/* verification/per_far_side.sv */
`timescale 1ns/1ps

// stand-in for the peripherals and the servicing core
module per_far_side (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire per_pkg::per_src_t src_cmd_i, // bench asks a source to raise
	input wire per_pkg::per_evt_t core_cmd_i, // bench asks a direct core event
	input wire logic accept_en_i, // core willing to take requests
	input wire per_pkg::per_evt_t evt_req_i, // requests seen by the core
	output per_pkg::per_src_t periph_src_o,
	output per_pkg::per_evt_t core_evt_o,
	output per_pkg::per_evt_t evt_accept_o
);
	import per_pkg::*;

	// ------------------------------------------------------------
	// sources and core
	// ------------------------------------------------------------
	// accept is a one-cycle pulse with a gap, so a request is never taken twice
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			periph_src_o <= '0;
			core_evt_o <= '0;
			evt_accept_o <= '0;
		end else begin
			periph_src_o <= src_cmd_i;
			core_evt_o <= core_cmd_i;
			evt_accept_o <= (accept_en_i && evt_accept_o == '0) ? evt_req_i : '0;
		end
	end
endmodule : per_far_side

/* verification/per_event_router_bench.sv */
`timescale 1ns/1ps
`include "per_defs.svh"

module per_event_router_bench;
	import per_pkg::*;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic supervisor_i = 1'b1; // privilege seen by the block
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h00000000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic accept_en = 1'b0; // lets the core model take requests
	per_src_t src_cmd = '0;
	per_evt_t core_cmd = '0;
	per_src_t periph_src;
	per_evt_t core_evt;
	per_evt_t evt_accept;
	per_evt_t evt_req;
	logic [31:0] rdata;
	logic irq;
	int num_errors = 0;
	int tests_run = 0;

	// ------------------------------------------------------------
	// clock and instances
	// ------------------------------------------------------------
	always #20 ref_clk_i = ~ref_clk_i;

	per_event_router uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.periph_src_i(periph_src), .core_evt_i(core_evt), .evt_accept_i(evt_accept),
		.supervisor_i(supervisor_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata), .evt_req_o(evt_req), .irq_o(irq));

	per_far_side far (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .src_cmd_i(src_cmd),
		.core_cmd_i(core_cmd), .accept_en_i(accept_en), .evt_req_i(evt_req),
		.periph_src_o(periph_src), .core_evt_o(core_evt), .evt_accept_o(evt_accept));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// single-cycle write strobe; the leading edge wait keeps strobes apart
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(what, rdata, exp);
	endtask : rchk

	// routed level of a source after reset, as value minus seven
	function automatic logic [3:0] lvl_of(input int i);
		if (i <= 10 || i >= 60) return 4'h0;
		if (i <= 22 || i == 53 || i == 54) return 4'h1;
		if (i <= 34 || i == 55 || i == 56) return 4'h2;
		if (i <= 46) return 4'h3;
		if (i <= 52) return 4'h4;
		if (i <= 58) return 4'h5;
		return 4'h6;
	endfunction : lvl_of

	// source held long enough to pass the router stage, then dropped
	task automatic fire(input int s);
		@(posedge ref_clk_i);
		src_cmd[s] <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		src_cmd[s] <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask : fire

	// ------------------------------------------------------------
	// hang guard
	// ------------------------------------------------------------
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		num_errors++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] exp;
		logic [7:0] adr; // assignment word offset
		int srcs[10] = '{0, 11, 23, 35, 47, 53, 55, 57, 59, 62};
		repeat (3) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		// default assignment bank
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 8; i++) exp[4*i +: 4] = lvl_of(8*k + i);
			adr = `PER_OFS_ASSIGN_BASE + 8'(4*k);
			rchk("assign", adr, exp);
		end
		rchk("latch", `PER_OFS_LATCH, 32'h00000000);
		rchk("mask", `PER_OFS_MASK, 32'h00000000);
		// one source per class lands on its level; masked so no request
		foreach (srcs[j]) begin
			fire(srcs[j]);
			rchk("latch", `PER_OFS_LATCH, 32'h1 << (7 + lvl_of(srcs[j])));
			chk("evt_req", 32'(evt_req), 32'h00000000);
			wr(`PER_OFS_LATCH, 32'h0000FFFF);
			rchk("cancel", `PER_OFS_LATCH, 32'h00000000);
		end
		// remap the watchdog onto level eight
		wr(`PER_OFS_ASSIGN_BASE + 8'h1C, 32'h00001000);
		fire(59);
		rchk("remap", `PER_OFS_LATCH, 32'h00000100);
		wr(`PER_OFS_LATCH, 32'h0000FFFF);
		// direct core event, unmasked, then a refused cancel of a masked-on bit
		wr(`PER_OFS_MASK, 32'h00002008);
		@(posedge ref_clk_i);
		core_cmd <= 16'h0008;
		@(posedge ref_clk_i);
		core_cmd <= 16'h0000;
		repeat (2) @(posedge ref_clk_i);
		chk("evt_req", 32'(evt_req), 32'h00000008);
		wr(`PER_OFS_LATCH, 32'h00000008);
		rchk("locked", `PER_OFS_LATCH, 32'h00000008);
		rchk("irq_stat", `PER_OFS_IRQ_STAT, 32'h00000002);
		// core takes the request
		accept_en <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		accept_en <= 1'b0;
		chk("evt_req", 32'(evt_req), 32'h00000000);
		rchk("accepted", `PER_OFS_LATCH, 32'h00000000);
		// pending event under a clear mask bit, so user access has something to hide
		@(posedge ref_clk_i);
		core_cmd <= 16'h0002;
		@(posedge ref_clk_i);
		core_cmd <= 16'h0000;
		// user mode: writes ignored, latch hidden, other reads work
		@(posedge ref_clk_i);
		supervisor_i <= 1'b0;
		wr(`PER_OFS_MASK, 32'h00000000);
		wr(`PER_OFS_LATCH, 32'h0000FFFF);
		rchk("user_latch", `PER_OFS_LATCH, 32'h00000000);
		rchk("user_mask", `PER_OFS_MASK, 32'h00002008);
		@(posedge ref_clk_i);
		supervisor_i <= 1'b1;
		rchk("user_kept", `PER_OFS_LATCH, 32'h00000002);
		rchk("irq_stat", `PER_OFS_IRQ_STAT, 32'h00000003);
		// interrupt raised only once unmasked, dropped by write-one-clear
		chk("irq_masked", 32'(irq), 32'h00000000);
		wr(`PER_OFS_IRQ_MASK, 32'h00000003);
		#1;
		chk("irq", 32'(irq), 32'h00000001);
		wr(`PER_OFS_IRQ_STAT, 32'h00000003);
		#1;
		chk("irq_clr", 32'(irq), 32'h00000000);
		rchk("irq_stat", `PER_OFS_IRQ_STAT, 32'h00000000);
		rchk("unmapped", 8'h30, 32'h00000000);
		wrap_up();
	end
endmodule : per_event_router_bench
